// ---- hdl/scp_pkg.sv ----
/*
  scp_pkg: constants and carrier types for the system configuration,
  power and indirect-address register slice.
  Assumes a 32-bit APB master; printed offsets are register indices and
  the byte address is four times the index.
*/
package scp_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [13:0] IDX_PWR    = 14'h0014;
  localparam logic [13:0] IDX_SRST   = 14'h0016;
  localparam logic [13:0] IDX_CLKDIV = 14'h0018;
  localparam logic [13:0] IDX_RSVD   = 14'h0020;
  localparam logic [13:0] IDX_ADDRLO = 14'h0022;
  localparam logic [13:0] IDX_ADDRHI = 14'h0024;
  localparam logic [13:0] IDX_POLICY = 14'h0026;
  localparam logic [13:0] IDX_LOCK_LO = 14'h0030;
  localparam logic [13:0] IDX_LOCK_HI = 14'h0a0e;

  localparam logic [15:0] BA_PWR    = {IDX_PWR,    2'b00};
  localparam logic [15:0] BA_SRST   = {IDX_SRST,   2'b00};
  localparam logic [15:0] BA_CLKDIV = {IDX_CLKDIV, 2'b00};
  localparam logic [15:0] BA_RSVD   = {IDX_RSVD,   2'b00};
  localparam logic [15:0] BA_ADDRLO = {IDX_ADDRLO, 2'b00};
  localparam logic [15:0] BA_ADDRHI = {IDX_ADDRHI, 2'b00};
  localparam logic [15:0] BA_POLICY = {IDX_POLICY, 2'b00};

  // ---------------------------------------------------------------
  // field positions of the power / bypass control register
  // ---------------------------------------------------------------
  localparam int PWR_WIDTH_BIT = 12;
  localparam int PWR_ORDER_BIT = 11;
  localparam int PWR_MODE_LSB  = 8;
  localparam int PWR_VBLK_BIT  = 7;
  localparam int PWR_IDLE_BIT  = 6;
  localparam int PWR_PULL_BIT  = 4;
  localparam int PWR_PSAVE_BIT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        RST_PULL   = 1'b1;
  localparam logic        RST_PSAVE  = 1'b1;
  localparam logic [1:0]  RST_CLKDIV = 2'h0;
  localparam logic [17:0] RST_ADDR   = 18'h00000;
  localparam logic [1:0]  RST_POLICY = 2'h0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BYP_OFF   = 3'b000,
    BYP_M2_P1 = 3'b001,
    BYP_S2    = 3'b010,
    BYP_M3_P  = 3'b011,
    BYP_M4_P2 = 3'b100
  } scp_bypass_mode_e;

  typedef enum logic [1:0] {
    PIF_MODE1 = 2'b00,
    PIF_MODE4 = 2'b01,
    PIF_MODE2 = 2'b10,
    PIF_MODE3 = 2'b11
  } scp_panel_if_e;

  typedef enum logic [1:0] {
    INC_HIGH_OR_WORD = 2'b00,
    INC_WORD_ONLY    = 2'b01,
    INC_NEVER        = 2'b10
  } scp_inc_policy_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic lcd1_par;
    logic lcd2_ser;
    logic lcd2_par;
  } scp_bypass_s;

  typedef struct packed {
    logic cs_up;
    logic clk_down;
    logic cmd_down;
    logic si_down;
  } scp_pull_s;

  typedef struct packed {
    logic done;
    logic word;
    logic high_byte;
  } scp_mem_access_s;

endpackage

// ---- hdl/scp_regs.sv ----
/*
  scp_regs: system configuration slice on APB - bypass mode decode,
  status flags, pull resistor and power save control, software reset,
  system clock divider enable and the indirect memory address counter.
  Assumes a single clock pclk at 250 MHz, asynchronous active-low
  presetn, and that panel mode, bypass enable and status flags arrive
  synchronous to pclk from neighbouring blocks.
*/
//
// Contract
// (RQ1) bypass code 000 disables every panel bypass path
// (RQ2) code 001 in mode 2: panel one parallel bypass only
// (RQ3) code 010 in mode 1 or 2: panel two serial bypass
// (RQ4) code 011 in mode 3: both parallel, host selects pick panel
// (RQ5) code 100 in mode 4: panel two parallel; 101-111 reserved
// (RQ6) host sets bypass code before raising port bypass enable
// (RQ7) bit 7 reads vertical blank, only for RGB panel modes
// (RQ8) bit 6 reads memory controller idle
// (RQ9) host sees idle flag 1 before power save or PLL off
// (RQ10) bit 4 drives host pin pull resistors, default on
// (RQ11) host clears pull enable in mode 3 with code 011
// (RQ12) bit 0 is power save, reset value 1
// (RQ13) host turns LCD output port off before power save
// (RQ14) any write to reset register restores defaults, buffer kept
// (RQ15) clock divide 00..11 gives 1:1 to 4:1
// (RQ16) indirect address bits 18:1 advance after each access
// (RQ17) indirect interface handles 16-bit accesses only
// (RQ18) policy 00 advances on high byte or word access
// (RQ19) policy 01 advances on word access only
// (RQ20) policy 10 never advances
// (RQ21) host never writes the reserved register
// (RQ22) power save makes the 0030h..0A0Eh range inaccessible
// (RQ23) soft reset leaves 0000h..0018h contents unchanged
// (RQ24) each advance adds one word, carrying into upper bits
`timescale 1ns/1ps

module scp_regs
  import scp_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [15:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [1:0]      panel_if_mode,
  input  wire logic            port_bypass_en,
  input  wire logic            host_serial_chip_select_n,
  input  wire logic            panel_two_select_n,
  input  wire logic            vertical_blank_flag,
  input  wire logic            mem_ctrl_idle,
  input  wire logic            pll_disabled,
  input  wire logic            indirect_if_sel,
  input  wire scp_mem_access_s mem_access,
  output scp_bypass_s          bypass,
  output scp_pull_s            pull_en,
  output logic                 power_save,
  output logic                 soft_reset,
  output logic                 sys_clk_en,
  output logic                 sys_src_ext,
  output logic      [17:0]     ind_addr,
  output logic                 byte_refused
);

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  logic        pready_ff;
  logic        nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        access;
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_val;

  // registers in the config group
  logic             width_ff;
  logic             order_ff;
  logic [2:0]       mode_ff;
  logic             pull_ff;
  logic             psave_ff;
  logic [1:0]       clkdiv_ff;
  logic             nxt_width;
  logic             nxt_order;
  logic [2:0]       nxt_mode;
  logic             nxt_pull;
  logic             nxt_psave;
  logic [1:0]       nxt_clkdiv;

  // indirect group
  logic [17:0]      addr_ff;
  logic [1:0]       policy_ff;
  logic [17:0]      nxt_addr;
  logic [1:0]       nxt_policy;
  logic             wr_addr;
  logic             advance;

  logic             rgb_panel;
  logic             vblank_live;

  assign access  = psel && penable && !pready_ff;
  assign wr_en   = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign wr_addr = wr_en && (paddr == BA_ADDRLO || paddr == BA_ADDRHI);

  assign rgb_panel   = (panel_if_mode == PIF_MODE1) ||
                       (panel_if_mode == PIF_MODE4);
  assign vblank_live = vertical_blank_flag && rgb_panel; // RQ7

  // read decode; unmapped and locked addresses answer with an error
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      BA_PWR: begin
        rd_val[PWR_WIDTH_BIT]            = width_ff;
        rd_val[PWR_ORDER_BIT]            = order_ff;
        rd_val[PWR_MODE_LSB +: 3]        = mode_ff;
        rd_val[PWR_VBLK_BIT]             = vblank_live; // RQ7
        rd_val[PWR_IDLE_BIT]             = mem_ctrl_idle; // RQ8
        rd_val[PWR_PULL_BIT]             = pull_ff;
        rd_val[PWR_PSAVE_BIT]            = psave_ff;
      end
      BA_SRST:   rd_val = 32'h00000000;
      BA_CLKDIV: rd_val[1:0] = clkdiv_ff;
      BA_RSVD:   rd_val = 32'h00000000;
      BA_ADDRLO: rd_val[15:1] = addr_ff[14:0];
      BA_ADDRHI: rd_val[2:0] = addr_ff[17:15];
      BA_POLICY: rd_val[1:0] = policy_ff;
      default:   rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_pready  = access;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (access) begin
      // locked window only matters to blocks behind other decoders
      nxt_pslverr = !rd_hit; // RQ22
      nxt_prdata  = (rd_hit && !pwrite) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // ---------------------------------------------------------------
  // configuration group, untouched by soft reset
  // ---------------------------------------------------------------
  always_comb begin
    nxt_width  = width_ff;
    nxt_order  = order_ff;
    nxt_mode   = mode_ff;
    nxt_pull   = pull_ff;
    nxt_psave  = psave_ff;
    nxt_clkdiv = clkdiv_ff;
    if (wr_en && paddr == BA_PWR) begin
      nxt_width = pwdata[PWR_WIDTH_BIT];
      nxt_order = pwdata[PWR_ORDER_BIT];
      nxt_mode  = pwdata[PWR_MODE_LSB +: 3];
      nxt_pull  = pwdata[PWR_PULL_BIT]; // RQ10
      nxt_psave = pwdata[PWR_PSAVE_BIT]; // RQ12
    end
    if (wr_en && paddr == BA_CLKDIV) begin
      nxt_clkdiv = pwdata[1:0]; // RQ15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_ff  <= 1'b0;
      order_ff  <= 1'b0;
      mode_ff   <= BYP_OFF;
      pull_ff   <= RST_PULL;
      psave_ff  <= RST_PSAVE; // RQ12
      clkdiv_ff <= RST_CLKDIV;
    end else begin
      width_ff  <= nxt_width;
      order_ff  <= nxt_order;
      mode_ff   <= nxt_mode;
      pull_ff   <= nxt_pull;
      psave_ff  <= nxt_psave;
      clkdiv_ff <= nxt_clkdiv;
    end
  end

  // ---------------------------------------------------------------
  // indirect address counter
  // ---------------------------------------------------------------
  logic srst_wr;
  logic is_byte;
  assign srst_wr = wr_en && paddr == BA_SRST; // RQ14
  assign is_byte = mem_access.done && !mem_access.word;

  always_comb begin
    advance = 1'b0;
    if (mem_access.done) begin
      case (policy_ff)
        INC_HIGH_OR_WORD: advance = mem_access.word ||
                                    (mem_access.high_byte &&
                                     !indirect_if_sel); // RQ18 RQ17
        INC_WORD_ONLY:    advance = mem_access.word; // RQ19
        INC_NEVER:        advance = 1'b0; // RQ20
        default:          advance = 1'b0;
      endcase
    end
  end

  always_comb begin
    nxt_addr   = addr_ff;
    nxt_policy = policy_ff;
    if (advance) begin
      nxt_addr = addr_ff + 18'h00001; // RQ16 RQ24
    end
    // a host write of ADDRLO or ADDRHI wins over a same-cycle advance only in the field it writes
    if (wr_en && paddr == BA_ADDRLO) begin
      nxt_addr[14:0] = pwdata[15:1];
    end
    if (wr_en && paddr == BA_ADDRHI) begin
      nxt_addr[17:15] = pwdata[2:0];
    end
    if (wr_en && paddr == BA_POLICY) begin
      nxt_policy = pwdata[1:0];
    end
    if (srst_wr) begin
      nxt_addr   = RST_ADDR; // RQ14 RQ23
      nxt_policy = RST_POLICY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff   <= RST_ADDR;
      policy_ff <= RST_POLICY;
    end else begin
      addr_ff   <= nxt_addr;
      policy_ff <= nxt_policy;
    end
  end

  // ---------------------------------------------------------------
  // system clock divider: one-cycle enable every div+1 cycles
  // ---------------------------------------------------------------
  logic [1:0] div_cnt_ff;
  logic [1:0] nxt_div_cnt;
  logic       nxt_clk_en;

  always_comb begin
    nxt_clk_en  = (div_cnt_ff >= clkdiv_ff);
    nxt_div_cnt = nxt_clk_en ? 2'h0 : div_cnt_ff + 2'h1; // RQ15
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  scp_bypass_s bypass_ff;
  scp_bypass_s nxt_bypass;
  scp_pull_s   pull_en_ff;
  scp_pull_s   nxt_pull_en;
  logic        sys_clk_en_ff;
  logic        soft_reset_ff;
  logic        sys_src_ext_ff;
  logic        byte_refused_ff;
  logic        lcd1_pick;
  logic        lcd2_pick;

  // in mode 3 the host's select pins choose the bypassed panel
  assign lcd1_pick = !host_serial_chip_select_n; // RQ4
  assign lcd2_pick = !panel_two_select_n; // RQ4

  always_comb begin
    // reserved codes and code 000 leave every path closed
    nxt_bypass = '0; // RQ1 RQ5
    if (port_bypass_en) begin
      case (mode_ff)
        BYP_M2_P1: nxt_bypass.lcd1_par =
                     (panel_if_mode == PIF_MODE2); // RQ2
        BYP_S2:    nxt_bypass.lcd2_ser =
                     (panel_if_mode == PIF_MODE1) ||
                     (panel_if_mode == PIF_MODE2); // RQ3
        BYP_M3_P: begin
          nxt_bypass.lcd1_par = (panel_if_mode == PIF_MODE3) &&
                                lcd1_pick; // RQ4
          nxt_bypass.lcd2_par = (panel_if_mode == PIF_MODE3) &&
                                lcd2_pick; // RQ4
        end
        BYP_M4_P2: nxt_bypass.lcd2_par =
                     (panel_if_mode == PIF_MODE4); // RQ5
        default:   nxt_bypass = '0;
      endcase
    end
    nxt_pull_en = {4{pull_ff}}; // RQ10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_ff       <= '0;
      pull_en_ff      <= {4{RST_PULL}};
      sys_clk_en_ff   <= 1'b0;
      soft_reset_ff   <= 1'b0;
      sys_src_ext_ff  <= 1'b0;
      byte_refused_ff <= 1'b0;
    end else begin
      bypass_ff       <= nxt_bypass;
      pull_en_ff      <= nxt_pull_en;
      sys_clk_en_ff   <= nxt_clk_en;
      soft_reset_ff   <= srst_wr;
      sys_src_ext_ff  <= pll_disabled;
      byte_refused_ff <= is_byte && indirect_if_sel; // RQ17
    end
  end

  assign bypass       = bypass_ff;
  assign pull_en      = pull_en_ff;
  assign power_save   = psave_ff;
  assign soft_reset   = soft_reset_ff;
  assign sys_clk_en   = sys_clk_en_ff;
  assign sys_src_ext  = sys_src_ext_ff;
  assign ind_addr     = addr_ff;
  assign byte_refused = byte_refused_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pwr_write(logic [31:0] mask, logic [31:0] val);
    wr_en && paddr == BA_PWR && ((pwdata & mask) == val);
  endsequence

  sequence s_pwr_read;
    access && !pwrite && paddr == BA_PWR;
  endsequence

  chk_bypass_off: assert property ( // RQ1
    mode_ff == BYP_OFF |=> bypass_ff == '0)
    else $error("bypass open with code 000");

  chk_bypass_m2: assert property ( // RQ2
    port_bypass_en && mode_ff == BYP_M2_P1 &&
    panel_if_mode == PIF_MODE2
    |=> bypass_ff.lcd1_par && !bypass_ff.lcd2_ser)
    else $error("code 001 decode wrong");

  chk_bypass_s2: assert property ( // RQ3
    port_bypass_en && mode_ff == BYP_S2 &&
    (panel_if_mode == PIF_MODE1 || panel_if_mode == PIF_MODE2)
    |=> bypass_ff.lcd2_ser && !bypass_ff.lcd1_par)
    else $error("code 010 decode wrong");

  chk_bypass_m3: assert property ( // RQ4
    port_bypass_en && mode_ff == BYP_M3_P &&
    panel_if_mode == PIF_MODE3
    |=> bypass_ff.lcd1_par == $past(lcd1_pick) &&
        bypass_ff.lcd2_par == $past(lcd2_pick))
    else $error("code 011 panel pick wrong");

  chk_bypass_m4: assert property ( // RQ5
    port_bypass_en && mode_ff == BYP_M4_P2 &&
    panel_if_mode == PIF_MODE4
    |=> bypass_ff.lcd2_par && !bypass_ff.lcd1_par)
    else $error("code 100 decode wrong");

  chk_vblank_read: assert property ( // RQ7
    s_pwr_read |=> prdata_ff[PWR_VBLK_BIT] == $past(vblank_live))
    else $error("vertical blank bit wrong");

  chk_idle_read: assert property ( // RQ8
    s_pwr_read |=> prdata_ff[PWR_IDLE_BIT] == $past(mem_ctrl_idle))
    else $error("idle bit wrong");

  chk_pull_off: assert property ( // RQ10
    s_pwr_write(32'h00000010, 32'h00000000) |=> ##1 pull_en_ff == '0)
    else $error("pull resistors still on");

  chk_psave_set: assert property ( // RQ12
    s_pwr_write(32'h00000001, 32'h00000001) |=> power_save [*2])
    else $error("power save not entered");

  chk_srst_keep: assert property ( // RQ14
    srst_wr |=> addr_ff == RST_ADDR && policy_ff == RST_POLICY &&
                $stable(pull_ff) && $stable(clkdiv_ff) ##0 soft_reset_ff)
    else $error("soft reset effect wrong");

  chk_div_four: assert property ( // RQ15
    (clkdiv_ff == 2'h3) [*5] |-> sys_clk_en_ff ==
      $past(sys_clk_en_ff, 4) && !(sys_clk_en_ff && $past(sys_clk_en_ff)))
    else $error("4:1 divider period wrong");

  chk_inc_word: assert property ( // RQ18
    mem_access.done && mem_access.word && !policy_ff[1] &&
    !wr_addr && !srst_wr |=> addr_ff == $past(addr_ff) + 18'h00001)
    else $error("word access did not advance");

  chk_inc_byte: assert property ( // RQ19
    mem_access.done && !mem_access.word &&
    policy_ff == INC_WORD_ONLY && !wr_addr && !srst_wr |=> $stable(addr_ff))
    else $error("byte access advanced");

  chk_inc_never: assert property ( // RQ20
    policy_ff == INC_NEVER && !wr_addr && !srst_wr |=> $stable(addr_ff))
    else $error("address advanced with policy 10");

  chk_apb_ready: assert property (
    access |=> pready_ff ##1 !pready_ff)
    else $error("pready not one cycle");

endmodule

// ---- tb/scp_host_bfm.sv ----
/*
  scp_host_bfm: host side model, an apb master plus the memory access
  strobe source. Assumes one clock, the bench calls its tasks.
*/
`timescale 1ns/1ps

module scp_host_bfm
  import scp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  output scp_mem_access_s  mem_access
);
  // ---------------------------------------------------------------
  // expected answers, oldest first, popped by the bench monitor
  // ---------------------------------------------------------------
  logic [32:0] exp_q[$];

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    mem_access = '0;
  end

  // holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // whole 16-bit words, high bytes and low bytes can all be issued by this host
  task automatic mem(input logic w, input logic h);
    @(posedge pclk);
    mem_access <= '{1'b1, w, h};
    @(posedge pclk);
    mem_access <= '0;
  endtask
endmodule

// ---- tb/scp_regs_tb.sv ----
/*
  scp_regs_tb: self-checking bench for the configuration slice.
  Assumes scp_host_bfm as the apb master and a 250 MHz pclk.
*/
`timescale 1ns/1ps

module scp_regs_tb
  import scp_pkg::*;
;
  logic            pclk = 1'b0;
  logic            presetn;
  logic            psel, penable, pwrite, pready, pslverr;
  logic [15:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [1:0]      mode;
  logic            byp_en, cs_n, p2_n, vblank, idle, pll_dis, ind_sel;
  scp_mem_access_s mem_access;
  scp_bypass_s     bypass;
  scp_pull_s       pull_en;
  logic            power_save, soft_reset, sys_clk_en, sys_src_ext;
  logic            byte_refused;
  logic [17:0]     ind_addr, exp_a;
  logic [32:0]     exp_e;
  int              err_count = 0;
  int              n_checks = 0;
  int              n;
  logic [2:0]      r;

  always #2 pclk = ~pclk;

  scp_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_if_mode(mode), .port_bypass_en(byp_en),
    .host_serial_chip_select_n(cs_n), .panel_two_select_n(p2_n),
    .vertical_blank_flag(vblank), .mem_ctrl_idle(idle),
    .pll_disabled(pll_dis), .indirect_if_sel(ind_sel),
    .mem_access(mem_access), .bypass(bypass), .pull_en(pull_en),
    .power_save(power_save), .soft_reset(soft_reset),
    .sys_clk_en(sys_clk_en), .sys_src_ext(sys_src_ext),
    .ind_addr(ind_addr), .byte_refused(byte_refused));

  scp_host_bfm host_u (.pclk(pclk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .mem_access(mem_access));

  // ---------------------------------------------------------------
  // compare tasks and bus monitor
  // ---------------------------------------------------------------
  task automatic check_bus(input logic [32:0] got, input logic [32:0] e);
    n_checks++;
    if (got !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic check_val(input logic [17:0] got, input logic [17:0] e);
    n_checks++;
    if (got !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      exp_e = host_u.exp_q.pop_front();
      check_bus({pslverr, prdata}, exp_e);
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    give_verdict;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // bypass table: code, panel mode, expected {lcd1_par,lcd2_ser,lcd2_par}
  logic [2:0] t_code[8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [1:0] t_mode[8] = '{2'h3, 2'h2, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [2:0] t_exp[8]  = '{3'h0, 3'h4, 3'h0, 3'h2, 3'h2, 3'h4, 3'h1, 3'h0};
  // policy, word, high byte, advance
  logic [1:0] p_pol[7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [2:0] p_acc[7] = '{3'h5, 3'h3, 3'h0, 3'h5, 3'h2, 3'h4, 3'h4};

  initial begin
    void'($urandom(36));
    presetn <= 1'b0;
    {mode, byp_en, cs_n, p2_n, pll_dis, ind_sel} <= 7'b0000_100;
    {vblank, idle} <= 2'b11;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    host_u.apb(1'b0, BA_PWR, 32'h0, 33'h0_0000_00d1);
    check_val(pull_en, 18'hf);
    check_val(power_save, 18'h1);
    host_u.apb(1'b0, BA_CLKDIV, 32'h0, 33'h0);
    host_u.apb(1'b0, BA_POLICY, 32'h0, 33'h0);
    mode <= 2'h3;
    host_u.apb(1'b0, BA_PWR, 32'h0, 33'h0_0000_0051);
    host_u.apb(1'b0, 16'h00c0, 32'h0, 33'h1_0000_0000);
    host_u.apb(1'b0, BA_RSVD, 32'h0, 33'h0);
    for (int i = 0; i < 8; i++) begin
      mode <= t_mode[i];
      // code first, then the port enable
      host_u.apb(1'b1, BA_PWR, {21'h0, t_code[i], 8'h00}, 33'h0);
      byp_en <= 1'b1;
      repeat (3) @(posedge pclk);
      check_val(bypass, t_exp[i]);
      byp_en <= 1'b0;
    end
    check_val(pull_en, 18'h0);
    check_val(power_save, 18'h0);
    for (int d = 0; d < 4; d++) begin
      host_u.apb(1'b1, BA_CLKDIV, d, 33'h0);
      repeat (6) @(posedge pclk);
      n = 0;
      while (sys_clk_en !== 1'b1 && n < 10) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sys_clk_en !== 1'b1 && n < 10);
      check_val(18'(n), 18'(d + 1));
    end
    r = $urandom;
    exp_a = {r, 15'h7fff};
    host_u.apb(1'b1, BA_ADDRLO, 32'hfffe, 33'h0);
    host_u.apb(1'b1, BA_ADDRHI, r, 33'h0);
    for (int i = 0; i < 7; i++) begin
      host_u.apb(1'b1, BA_POLICY, p_pol[i], 33'h0);
      host_u.mem(p_acc[i][2], p_acc[i][1]);
      repeat (2) @(posedge pclk);
      exp_a = exp_a + p_acc[i][0];
      check_val(ind_addr, exp_a);
    end
    host_u.apb(1'b0, BA_ADDRLO, 32'h0, {17'h0, exp_a[14:0], 1'b0});
    host_u.apb(1'b0, BA_ADDRHI, 32'h0, {30'h0, exp_a[17:15]});
    ind_sel <= 1'b1;
    host_u.apb(1'b1, BA_POLICY, 32'h0, 33'h0);
    host_u.mem(1'b0, 1'b1);
    @(posedge pclk);
    check_val(byte_refused, 18'h1);
    check_val(ind_addr, exp_a);
    ind_sel <= 1'b0;
    host_u.apb(1'b1, BA_POLICY, 32'h1, 33'h0);
    host_u.apb(1'b1, BA_SRST, $urandom, 33'h0);
    @(posedge pclk);
    check_val(soft_reset, 18'h1);
    check_val(ind_addr, 18'h0);
    host_u.apb(1'b0, BA_POLICY, 32'h0, 33'h0);
    host_u.apb(1'b0, BA_CLKDIV, 32'h0, 33'h3);
    host_u.apb(1'b0, BA_PWR, 32'h0, 33'h0_0000_05c0);
    // idle read as 1 above; mode 1 needs no output port shutdown
    mode <= 2'h0;
    host_u.apb(1'b1, BA_PWR, 32'h1, 33'h0);
    @(posedge pclk);
    check_val(power_save, 18'h1);
    host_u.apb(1'b0, BA_PWR, 32'h0, 33'h0_0000_00c1);
    pll_dis <= 1'b1;
    repeat (3) @(posedge pclk);
    check_val(sys_src_ext, 18'h1);
    give_verdict;
  end
endmodule
